//--- design/psw_flags_core.sv
// Purpose: status word, flag logic, interrupt gate and register banks
// Assumes: requests synchronous to REF_CLK_IN; APB slave, no wait states
// Notes: APB write to the status word wins over a same-cycle ALU update
// How it works
// RQ1: Status word is bank pointer high byte over condition code low byte.
// RQ2: Half carry set on carry 3 to 4 or borrow 4 to 3.
// RQ3: Interrupts pass only while enable flag is 1; reset clears it.
// RQ4: Request served only if its level beats mask; mask 3 blocks all.
// RQ5: Negative flag copies the result's top bit.
// RQ6: Zero flag set when the result is zero.
// RQ7: Overflow flag set on signed two's complement overflow.
// RQ8: Carry flag set on carry out of or borrow into bit 7.
// RQ9: Shifts load carry with the bit shifted out.
// RQ10: Sixteen banks of eight 8-bit general registers.
// RQ11: Bank starts at 0100 hex plus eight times the pointer.
// RQ12: Untouched flags hold; software writes update pointer and flags.
`timescale 1ns/1ns
`include "psw_params.svh"

module psw_flags_core (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic [31:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  input wire psw_pkg::alu_req_t ALU_REQ_IN,
  output logic [7:0] RESULT_OUT,
  output logic RESULT_VALID_OUT,
  input wire psw_pkg::irq_req_t IRQ_REQ_IN,
  output logic IRQ_TAKE_OUT,
  input wire psw_pkg::gpr_req_t GPR_REQ_IN,
  output logic [7:0] GPR_RDATA_OUT,
  output logic [15:0] BANK_ADDR_OUT,
  output logic [15:0] GPR_ADDR_OUT,
  output logic [15:0] PROGRAM_STATUS_WORD_OUT
);
  import psw_pkg::*;

  localparam int BANK_BITS = $clog2(`PSW_BANK_COUNT);
  localparam int SEL_BITS = $clog2(`PSW_REGS_PER_BANK);
  localparam int GPR_DEPTH = `PSW_BANK_COUNT * `PSW_REGS_PER_BANK;

  logic [7:0] bank_pointer_r;
  ccr_t condition_code_field_r;
  ccr_t ccr_nxt;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic write_result;
  logic result_valid_r;
  logic [31:0] rdata_r;
  logic err_r;
  logic [15:0] bank_addr_r;
  logic [7:0] gpr_rdata_r;
  logic [7:0] gpr_mem [0:GPR_DEPTH-1];

  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic addr_hit;
  logic status_wr;

  logic [8:0] sum9;
  logic [4:0] sum_lo;
  logic [8:0] dif9;
  logic [4:0] dif_lo;
  logic cin;
  logic [BANK_BITS+SEL_BITS-1:0] gpr_index;

  // Zero wait states: read data is captured in the setup cycle
  assign apb_setup = PSEL_IN && !PENABLE_IN;
  assign apb_access = PSEL_IN && PENABLE_IN;
  assign apb_wr = apb_access && PWRITE_IN;
  assign addr_hit = (PADDR_IN == `PSW_OFS_STATUS) ||
                    (PADDR_IN == `PSW_OFS_BANK_ADDR) ||
                    (PADDR_IN == `PSW_OFS_RESULT);
  assign status_wr = apb_wr && (PADDR_IN == `PSW_OFS_STATUS);

  assign PREADY_OUT = apb_access;
  assign PRDATA_OUT = rdata_r;
  assign PSLVERR_OUT = apb_access && err_r;

  // Carry and borrow inputs for the chained forms
  always_comb begin
    case (ALU_REQ_IN.op)
      OP_ADDC: cin = condition_code_field_r.carry;
      OP_SUBC: cin = condition_code_field_r.carry;
      default: cin = 1'b0;
    endcase
  end

  always_comb begin
    sum9 = {1'b0, ALU_REQ_IN.a} + {1'b0, ALU_REQ_IN.b} + {8'h00, cin};
    sum_lo = {1'b0, ALU_REQ_IN.a[3:0]} + {1'b0, ALU_REQ_IN.b[3:0]} + {4'h0, cin};
    dif9 = {1'b0, ALU_REQ_IN.a} - {1'b0, ALU_REQ_IN.b} - {8'h00, cin};
    dif_lo = {1'b0, ALU_REQ_IN.a[3:0]} - {1'b0, ALU_REQ_IN.b[3:0]} - {4'h0, cin};
  end

  // Flag update; fields an operation does not define keep their value
  always_comb begin
    ccr_nxt = condition_code_field_r; // see RQ12
    result_nxt = result_r;
    write_result = 1'b0;
    if (ALU_REQ_IN.valid) begin
      case (ALU_REQ_IN.op)
        OP_ADD, OP_ADDC: begin
          result_nxt = sum9[7:0];
          write_result = 1'b1;
          ccr_nxt.half_carry = sum_lo[4]; // see RQ2
          ccr_nxt.carry = sum9[8]; // see RQ8
          ccr_nxt.overflow = (ALU_REQ_IN.a[7] == ALU_REQ_IN.b[7]) &&
                             (sum9[7] != ALU_REQ_IN.a[7]); // see RQ7
          ccr_nxt.negative = sum9[7]; // see RQ5
          ccr_nxt.zero = (sum9[7:0] == 8'h00); // see RQ6
        end
        OP_SUB, OP_SUBC, OP_CMP: begin
          result_nxt = (ALU_REQ_IN.op == OP_CMP) ? result_r : dif9[7:0];
          write_result = (ALU_REQ_IN.op != OP_CMP);
          ccr_nxt.half_carry = dif_lo[4]; // see RQ2
          ccr_nxt.carry = dif9[8]; // see RQ8
          ccr_nxt.overflow = (ALU_REQ_IN.a[7] != ALU_REQ_IN.b[7]) &&
                             (dif9[7] != ALU_REQ_IN.a[7]); // see RQ7
          ccr_nxt.negative = dif9[7]; // see RQ5
          ccr_nxt.zero = (dif9[7:0] == 8'h00); // see RQ6
        end
        OP_SHL: begin
          // Rotate through carry so multi-byte shifts chain
          result_nxt = {ALU_REQ_IN.a[6:0], condition_code_field_r.carry};
          write_result = 1'b1;
          ccr_nxt.carry = ALU_REQ_IN.a[7]; // see RQ9
          ccr_nxt.negative = ALU_REQ_IN.a[6]; // see RQ5
          ccr_nxt.zero = ({ALU_REQ_IN.a[6:0], condition_code_field_r.carry} == 8'h00); // see RQ6
        end
        OP_SHR: begin
          result_nxt = {condition_code_field_r.carry, ALU_REQ_IN.a[7:1]};
          write_result = 1'b1;
          ccr_nxt.carry = ALU_REQ_IN.a[0]; // see RQ9
          ccr_nxt.negative = condition_code_field_r.carry; // see RQ5
          ccr_nxt.zero = ({condition_code_field_r.carry, ALU_REQ_IN.a[7:1]} == 8'h00); // see RQ6
        end
        default: begin
          result_nxt = result_r;
          write_result = 1'b0;
        end
      endcase
    end
    // Software write is the later of the two and wins
    if (status_wr) begin
      ccr_nxt = ccr_t'(PWDATA_IN[7:0]); // see RQ12
    end
  end

  // Condition code field, reset clears the enable flag
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      condition_code_field_r <= ccr_t'(`PSW_RST_CCR); // see RQ3
    end else begin
      condition_code_field_r <= ccr_nxt;
    end
  end

  // Bank pointer, written only by software
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bank_pointer_r <= `PSW_RST_BANK_POINTER;
    end else if (status_wr) begin
      bank_pointer_r <= PWDATA_IN[15:8]; // see RQ1
    end
  end

  // Result register and its one-cycle strobe
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      result_r <= 8'h00;
      result_valid_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      result_valid_r <= write_result;
    end
  end

  assign RESULT_OUT = result_r;
  assign RESULT_VALID_OUT = result_valid_r;
  assign PROGRAM_STATUS_WORD_OUT = {bank_pointer_r, condition_code_field_r}; // see RQ1

  // Higher level number means higher priority, so a mask of 3 shuts all out
  assign IRQ_TAKE_OUT = IRQ_REQ_IN.valid &&
                        condition_code_field_r.irq_enable && // see RQ3
                        (IRQ_REQ_IN.level > condition_code_field_r.interrupt_level_mask); // see RQ4

  // Full pointer feeds the address; banks above 15 exceed the register area
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bank_addr_r <= `PSW_BANK_BASE;
    end else begin
      bank_addr_r <= `PSW_BANK_BASE + {5'h00, bank_pointer_r, 3'h0}; // see RQ11
    end
  end

  assign BANK_ADDR_OUT = bank_addr_r;
  assign GPR_ADDR_OUT = bank_addr_r + {13'h0000, GPR_REQ_IN.sel}; // see RQ11

  // Storage aliases on the low pointer bits beyond the sixteenth bank
  assign gpr_index = {bank_pointer_r[BANK_BITS-1:0], GPR_REQ_IN.sel}; // see RQ10

  // Register contents are undefined after reset, like the RAM they model
  always_ff @(posedge REF_CLK_IN) begin
    if (GPR_REQ_IN.we) begin
      gpr_mem[gpr_index] <= GPR_REQ_IN.wdata; // see RQ10
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      gpr_rdata_r <= 8'h00;
    end else if (!GPR_REQ_IN.we) begin
      gpr_rdata_r <= gpr_mem[gpr_index];
    end
  end

  assign GPR_RDATA_OUT = gpr_rdata_r;

  // Read mux captured in setup so the access phase needs no wait state
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (apb_setup) begin
      err_r <= !addr_hit;
      case (PADDR_IN)
        `PSW_OFS_STATUS: rdata_r <= {16'h0000, bank_pointer_r, condition_code_field_r};
        `PSW_OFS_BANK_ADDR: rdata_r <= {16'h0000, bank_addr_r};
        `PSW_OFS_RESULT: rdata_r <= {24'h00_0000, result_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

endmodule // psw_flags_core

//--- design/psw_params.svh
// Purpose: constants for the status word and register bank block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: bit positions index the 8-bit condition code field
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

`define PSW_OFS_STATUS 12'h000
`define PSW_OFS_BANK_ADDR 12'h004
`define PSW_OFS_RESULT 12'h008

`define PSW_BIT_H 7
`define PSW_BIT_I 6
`define PSW_BIT_IL1 5
`define PSW_BIT_IL0 4
`define PSW_BIT_N 3
`define PSW_BIT_Z 2
`define PSW_BIT_V 1
`define PSW_BIT_C 0

`define PSW_RST_BANK_POINTER 8'h00
`define PSW_RST_CCR 8'h30

`define PSW_BANK_BASE 16'h0100
`define PSW_BANK_SHIFT 3
`define PSW_BANK_COUNT 16
`define PSW_REGS_PER_BANK 8

`endif

//--- design/psw_pkg.sv
// Purpose: types shared by the status word block and its bench
// Assumes: constants come from psw_params.svh
// Notes: condition code layout matches the bit macros
package psw_pkg;

  typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_ADDC = 3'h1,
    OP_SUB = 3'h2,
    OP_SUBC = 3'h3,
    OP_CMP = 3'h4,
    OP_SHL = 3'h5,
    OP_SHR = 3'h6,
    OP_NONE = 3'h7
  } alu_op_t;

  typedef struct packed {
    logic half_carry;
    logic irq_enable;
    logic [1:0] interrupt_level_mask;
    logic negative;
    logic zero;
    logic overflow;
    logic carry;
  } ccr_t;

  typedef struct packed {
    logic valid;
    alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] level;
  } irq_req_t;

  typedef struct packed {
    logic we;
    logic [2:0] sel;
    logic [7:0] wdata;
  } gpr_req_t;

endpackage

//--- verification/psw_flags_core_sva.sv
// Purpose: checks on status word, flags, interrupt gate, bank address
// Assumes: zero-wait APB, flags one cycle after an ALU request
// Notes: ALU checks skip cycles carrying a status word write
`timescale 1ns/1ns
`include "psw_params.svh"
module psw_flags_core_sva (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire psw_pkg::alu_req_t ALU_REQ_IN,
  input wire logic [7:0] RESULT_OUT,
  input wire psw_pkg::irq_req_t IRQ_REQ_IN,
  input wire logic IRQ_TAKE_OUT,
  input wire logic [15:0] BANK_ADDR_OUT,
  input wire logic [15:0] PROGRAM_STATUS_WORD_OUT
);
  import psw_pkg::*;
  logic st_wr, go, wres, v;
  logic [8:0] sum;
  logic [4:0] hs;
  ccr_t f;
  assign st_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == `PSW_OFS_STATUS;
  assign go = ALU_REQ_IN.valid && !st_wr;
  assign wres = go && ALU_REQ_IN.op != OP_CMP && ALU_REQ_IN.op != OP_NONE;
  assign sum = {1'b0, ALU_REQ_IN.a} + {1'b0, ALU_REQ_IN.b};
  assign hs = {1'b0, ALU_REQ_IN.a[3:0]} + {1'b0, ALU_REQ_IN.b[3:0]};
  assign v = ALU_REQ_IN.a[7] == ALU_REQ_IN.b[7] && sum[7] != ALU_REQ_IN.a[7];
  assign f = PROGRAM_STATUS_WORD_OUT[7:0];
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  psw_write_a: assert property (st_wr |=> PROGRAM_STATUS_WORD_OUT == $past(PWDATA_IN[15:0]))
    else $error("status word write lost");
  add_carry_a: assert property (go && ALU_REQ_IN.op == OP_ADD |=> {f.carry, RESULT_OUT} == $past(sum))
    else $error("add carry or result wrong");
  add_half_a: assert property (go && ALU_REQ_IN.op == OP_ADD |=> f.half_carry == $past(hs[4]))
    else $error("half carry wrong");
  add_ovf_a: assert property (go && ALU_REQ_IN.op == OP_ADD |=> f.overflow == $past(v))
    else $error("overflow wrong");
  neg_flag_a: assert property (wres |=> f.negative == RESULT_OUT[7])
    else $error("negative flag wrong");
  zero_flag_a: assert property (wres |=> f.zero == (RESULT_OUT == 8'h00))
    else $error("zero flag wrong");
  shl_carry_a: assert property (go && ALU_REQ_IN.op == OP_SHL |=> f.carry == $past(ALU_REQ_IN.a[7]))
    else $error("shift carry wrong");
  irq_gate_a: assert property (1'b1 |-> IRQ_TAKE_OUT == (IRQ_REQ_IN.valid && f.irq_enable && IRQ_REQ_IN.level > f.interrupt_level_mask))
    else $error("interrupt gate wrong");
  mask_block_a: assert property (f.interrupt_level_mask == 2'b11 |-> !IRQ_TAKE_OUT)
    else $error("mask three let interrupt pass");
  bank_addr_a: assert property (1'b1 |=> BANK_ADDR_OUT == `PSW_BANK_BASE + {5'h0, $past(PROGRAM_STATUS_WORD_OUT[15:8]), 3'h0})
    else $error("bank address wrong");
  cover property (IRQ_TAKE_OUT);
  cover property (go && ALU_REQ_IN.op == OP_SHR);
  cover property (st_wr);
endmodule // psw_flags_core_sva
bind psw_flags_core psw_flags_core_sva psw_flags_core_sva_inst (.*);

//--- verification/psw_flags_core_tb.sv
// Purpose: directed bench for the status word block
// Assumes: zero-wait APB slave, flags one cycle after an ALU request
// Notes: like cases run from loops and one table
`timescale 1ns/1ns
`include "psw_params.svh"
module psw_flags_core_tb;
  import psw_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, rv, take, err;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, prd, rd;
  logic [7:0] res, gdat;
  logic [15:0] badr, gadr, psw;
  alu_req_t alu = '0;
  irq_req_t irq = '0;
  gpr_req_t gpr = '0;
  int errors = 0, n_compared = 0;
  // Expected result valid, op, a, b, result, condition code
  logic [39:0] tbl [9] = '{40'h80_0f01_10b0, 40'h80_8080_0037, 40'h81_7f00_80ba, 40'h82_1001_0fb0,
    40'h83_0001_ffb9, 40'h04_0505_ff34, 40'h85_8100_0231, 40'h86_0100_8039, 40'h07_0000_8039};
  always #4 clk = ~clk;
  psw_flags_core psw_flags_core_inst (.REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PREADY_OUT(pready), .PRDATA_OUT(prd),
    .PSLVERR_OUT(pslverr), .ALU_REQ_IN(alu), .RESULT_OUT(res), .RESULT_VALID_OUT(rv), .IRQ_REQ_IN(irq),
    .IRQ_TAKE_OUT(take), .GPR_REQ_IN(gpr), .GPR_RDATA_OUT(gdat), .BANK_ADDR_OUT(badr),
    .GPR_ADDR_OUT(gadr), .PROGRAM_STATUS_WORD_OUT(psw));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      test_done();
    end
    rd = prd;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `PSW_OFS_STATUS, '0);
    chk("status", 32'h0000_0030, rd);
    apb(1'b1, `PSW_OFS_BANK_ADDR, 32'h0000_ffff);
    apb(1'b0, `PSW_OFS_BANK_ADDR, '0);
    chk("bank addr reg", 32'h0000_0100, rd);
    apb(1'b0, 12'h00c, '0);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    $display("test registers done");
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, `PSW_OFS_STATUS, {25'h0, i[4:2], 4'h0});
      irq <= {1'b1, i[1:0]};
      @(posedge clk);
      chk("irq take", {31'h0, i[4] && i[1:0] > i[3:2]}, {31'h0, take});
    end
    irq <= '0;
    // Mid-run reset must drop the enable flag set by the last loop pass
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `PSW_OFS_STATUS, '0);
    chk("status after reset", 32'h0000_0030, rd);
    $display("test interrupts done");
    apb(1'b1, `PSW_OFS_STATUS, 32'h0000_0030);
    foreach (tbl[k]) begin
      @(posedge clk);
      alu <= {1'b1, tbl[k][34:32], tbl[k][31:16]};
      @(posedge clk);
      alu.valid <= 1'b0;
      @(posedge clk);
      chk("result", {24'h0, tbl[k][15:8]}, {24'h0, res});
      chk("flags", {24'h0, tbl[k][7:0]}, {16'h0, psw});
      chk("result valid", {31'h0, tbl[k][39]}, {31'h0, rv});
    end
    apb(1'b0, `PSW_OFS_RESULT, '0);
    chk("result reg", 32'h0000_0080, rd);
    $display("test alu done");
    for (int p = 0; p < 16; p++) begin
      apb(1'b1, `PSW_OFS_STATUS, {16'h0, p[7:0], 8'h30});
      gpr <= {1'b1, p[2:0], p[7:0] ^ 8'ha5};
      @(posedge clk);
      gpr.we <= 1'b0;
      @(posedge clk);
      chk("bank addr", 32'h0000_0100 + 8 * p, {16'h0, badr});
    end
    for (int p = 0; p < 16; p++) begin
      apb(1'b1, `PSW_OFS_STATUS, {16'h0, p[7:0], 8'h30});
      gpr <= {1'b0, p[2:0], 8'h00};
      repeat (3) @(posedge clk);
      chk("gpr", {24'h0, p[7:0] ^ 8'ha5}, {24'h0, gdat});
      chk("gpr addr", 32'h0000_0100 + 9 * (p % 8) + 64 * (p / 8), {16'h0, gadr});
    end
    $display("test banks done");
    test_done();
  end
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule // psw_flags_core_tb
